// file: rtl/olfc_oscillator_lock_failsafe_control.sv
/*
 * Oscillator lock, start-up, fail-safe and postscaler control.
 * Assumes oscillator status inputs already synchronous to sys_clk,
 * configuration straps stable while rst is low, APB master.
 */
// Function
// [R1] PLL multiplies by four, eight or sixteen per primary mode config.
// [R2] Read-only lock bit at bit 5, cleared by power-on reset.
// [R3] Lock only asserted after settle time following PLL start.
// [R4] PLL as destination clears lock; no lock keeps the old source.
// [R5] No lock at power-on with monitor enabled selects fast RC, traps.
// [R6] Four cycles out of lock clears lock bit and traps, PLL kept.
// [R7] Loss-of-lock trap works without monitor, source unchanged.
// [R8] Keep-on bit 1 set keeps secondary oscillator running.
// [R9] Else secondary runs only while source is 00, stops in sleep.
// [R10] Enabled secondary oscillator owns its two pins, GPIO cut off.
// [R11] Ten-bit start-up timer counts 1024 cycles before clock release.
// [R12] Start-up timer on every restart of secondary and crystal modes.
// [R13] Fast RC runs whenever current source field is 01.
// [R14] Slow RC on at power-on; after power-up timer only if needed.
// [R15] Monitor enabled keeps slow RC running except in sleep.
// [R16] Failure traps, loads source 01, sets fail flag, clears request.
// [R17] Monitoring starts 100 us after reset release for slow sources.
// [R18] Delay expiring before slow oscillator starts traps, selects RC.
// [R19] Clock failure leaves watchdog running on slow RC.
// [R20] Divide field at bits 7:6 writable at any time.
// [R21] New divide takes effect at next divide-by-64 falling edge.
// [R22] Switch config bit 1 disables switching and monitor.
// [R23] Source field at bits 13:12, fail flag at bit 3.
// [R24] Divide field 00,01,10,11 gives divide 1,4,16,64.
// [R25] Fail flag stays set until software clears it or reset; the code also clears it on a completed clock switch.
module olfc_oscillator_lock_failsafe_control #(
    parameter int LOCK_CYC = olfc_pkg::OLFC_LOCK_CYC,
    parameter int MON_CYC = olfc_pkg::OLFC_MON_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire olfc_pkg::olfc_cfg_t cfg,
    input wire logic sleepMode,
    input wire logic powerupTimerDone,
    input wire logic pllPhaseLocked,
    input wire logic oscSwingValid,
    input wire logic oscClockFail,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output olfc_pkg::olfc_osc_t oscEnable,
    output logic [1:0] currentSourceSel,
    output logic clockReleased,
    output logic clockFailTrap,
    output logic sysClockEnable,
    output logic secondaryPinsOwned,
    output logic watchdogClockOn
);
    import olfc_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Straps and configuration decode
    logic [1:0] csrcReg, csrcNext;
    logic [1:0] nsrcReg;
    logic swReqReg, keepOnReg, cfReg, lockReg;
    logic [1:0] divSelReg, divActReg;
    logic [OLFC_PRE_W-1:0] preReg;
    logic [10:0] startCntReg;
    logic startedReg;
    logic [$clog2(LOCK_CYC+1)-1:0] lockCntReg;
    logic [2:0] unlockCntReg;
    logic pllWasLockedReg;
    logic [$clog2(MON_CYC+1)-1:0] monCntReg;
    olfc_mon_t monStateReg, monStateNext;
    logic rstSeenReg, pwrtReg, trapReg;

    wire switchEnabled = ~cfg.switchMonitorConfigBit;  // [R22]
    wire monEnabled = ~cfg.switchMonitorConfigBit;  // [R22]
    wire powerOn = (cfg.resetSource != 2'h2);
    wire [3:0] pm = cfg.primaryModeConfig;
    wire modeXtal = (pm[3:2] == 2'b01);
    wire modePll = (pm[3:2] == 2'b10);
    wire [1:0] pllSel = pm[1:0];
    olfc_mul_t pllMul;
    assign pllMul = (!modePll) ? OLFC_MULOFF :
        (pllSel == 2'h0) ? OLFC_MUL4 :
        (pllSel == 2'h1) ? OLFC_MUL8 : OLFC_MUL16;  // [R1]
    wire [1:0] strapSrc = OLFC_SRC_PRI;

    ////////////////////////////////////////////////////////////////////
    // APB decode
    wire apbWr = psel & penable & pwrite;
    wire hitCtl = (paddr == OLFC_OSCCTL_OFS);
    wire hitSt = (paddr == OLFC_STATUS_OFS);
    wire wrCtl = apbWr & hitCtl;
    wire [1:0] wrNsrc = pwdata[OLFC_NSRC_LSB +: 2];
    wire wrSwReq = pwdata[OLFC_SWREQ_BIT];
    wire wrCfClr = wrCtl & ~pwdata[OLFC_CF_BIT];

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~(hitCtl | hitSt);

    ////////////////////////////////////////////////////////////////////
    // Source activity
    wire curPll = (csrcReg == OLFC_SRC_PRI) & modePll;
    wire curSec = (csrcReg == OLFC_SRC_SEC);
    wire curXtal = (csrcReg == OLFC_SRC_PRI) & modeXtal;
    wire needStart = curSec | curXtal;  // [R12]
    wire secOn = keepOnReg | (curSec & ~sleepMode);  // [R8] [R9]
    wire slowOn = ~pwrtReg | (monEnabled & ~sleepMode) |
        cfg.watchdogEnable | (csrcReg == OLFC_SRC_SLOW);  // [R14] [R15]
    wire fastOn = (csrcReg == OLFC_SRC_FAST);  // [R13]
    wire priOn = (csrcReg == OLFC_SRC_PRI) & ~sleepMode;
    wire pllStart = curPll | (swReqReg & nsrcReg == OLFC_SRC_PRI & modePll);

    assign oscEnable = '{secondaryOn: secOn, slowRcOn: slowOn,
        fastRcOn: fastOn, primaryOn: priOn, pllOn: pllStart & ~sleepMode,
        pllMul: pllMul};
    assign secondaryPinsOwned = secOn;  // [R10]
    assign watchdogClockOn = slowOn & cfg.watchdogEnable;  // [R19]

    ////////////////////////////////////////////////////////////////////
    // Start-up timer and lock detector
    wire startDone = startCntReg[10];
    wire lockSettled = (lockCntReg == LOCK_CYC[$bits(lockCntReg)-1:0]);
    wire lockTrue = lockSettled & pllPhaseLocked;
    wire unlockFault = curPll & pllWasLockedReg &
        (unlockCntReg == 3'(OLFC_UNLOCK_CYC - 1)) & ~pllPhaseLocked;  // [R6]
    wire switchTargetOk = (nsrcReg != OLFC_SRC_PRI) | ~modePll | lockReg;
    wire switchDo = switchEnabled & swReqReg & switchTargetOk &
        (nsrcReg != csrcReg);  // [R4]

    ////////////////////////////////////////////////////////////////////
    // Fail-safe monitor
    wire monSlowSrc = needStart | curPll;  // [R17]
    wire monExpired = (monCntReg == MON_CYC[$bits(monCntReg)-1:0]);
    wire srcReady = curPll ? lockReg : (needStart ? startedReg : 1'b1);
    wire monFail = monEnabled & ~fastOn & (
        ((monStateReg == OLFC_MON_WAIT) & monExpired & ~srcReady) |
        ((monStateReg == OLFC_MON_RUN) & oscClockFail));  // [R5] [R18]
    wire swReqClear = monFail | switchDo | (nsrcReg == csrcReg);

    always_comb begin
        monStateNext = monStateReg;
        case (monStateReg)
            OLFC_MON_IDLE: begin
                if (monEnabled && !rstSeenReg) begin
                    monStateNext = monSlowSrc ? OLFC_MON_WAIT : OLFC_MON_RUN;
                end
            end
            OLFC_MON_WAIT: begin
                if (monExpired) begin
                    monStateNext = OLFC_MON_RUN;  // [R17]
                end
            end
            OLFC_MON_RUN: begin
                if (sleepMode) begin
                    monStateNext = OLFC_MON_IDLE;
                end
            end
            default: monStateNext = OLFC_MON_IDLE;
        endcase
    end

    always_comb begin
        csrcNext = csrcReg;
        if (monFail) begin
            csrcNext = OLFC_SRC_FAST;  // [R16]
        end else if (switchDo) begin
            csrcNext = nsrcReg;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Postscaler
    wire preFall = (preReg == {OLFC_PRE_W{1'b1}});  // [R21]
    logic divTick;
    always_comb begin
        case (divActReg)  // [R24]
            2'h0: divTick = 1'b1;
            2'h1: divTick = (preReg[1:0] == 2'h3);
            2'h2: divTick = (preReg[3:0] == 4'hf);
            default: divTick = preFall;
        endcase
    end
    assign sysClockEnable = divTick & clockReleased;

    ////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            csrcReg <= 2'h3;
            nsrcReg <= OLFC_NSRC_RST;
            swReqReg <= 1'b0;
            keepOnReg <= 1'b0;
            cfReg <= 1'b0;
            divSelReg <= OLFC_DIV_RST;
            divActReg <= OLFC_DIV_RST;
            preReg <= '0;
            rstSeenReg <= 1'b1;
            pwrtReg <= 1'b0;
            trapReg <= 1'b0;
            monStateReg <= OLFC_MON_IDLE;
        end else begin
            if (rstSeenReg) begin
                csrcReg <= strapSrc;
                nsrcReg <= strapSrc;
            end else begin
                csrcReg <= csrcNext;
                if (wrCtl && switchEnabled) begin
                    nsrcReg <= wrNsrc;
                end
            end
            rstSeenReg <= 1'b0;
            monStateReg <= monStateNext;
            pwrtReg <= pwrtReg | powerupTimerDone;  // [R14]
            if (wrCtl) begin
                keepOnReg <= pwdata[OLFC_KEEPON_BIT];
                divSelReg <= pwdata[OLFC_DIV_LSB +: 2];  // [R20]
            end
            if (swReqClear) begin
                swReqReg <= 1'b0;  // [R16]
            end else if (wrCtl) begin
                swReqReg <= wrSwReq & switchEnabled;  // [R22]
            end
            if (monFail) begin
                cfReg <= 1'b1;  // [R16] [R25]
            end else if (switchDo || wrCfClr) begin
                cfReg <= 1'b0;
            end
            trapReg <= monFail | unlockFault;  // [R7]
            preReg <= preReg + 1'b1;
            if (preFall) begin
                divActReg <= divSelReg;  // [R21]
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || !pllStart || sleepMode) begin
            lockCntReg <= '0;
            lockReg <= 1'b0;  // [R2] [R4]
            unlockCntReg <= '0;
            pllWasLockedReg <= 1'b0;
        end else begin
            if (!lockSettled) begin
                lockCntReg <= lockCntReg + 1'b1;  // [R3]
            end
            if (lockTrue) begin
                pllWasLockedReg <= 1'b1;
            end
            if (pllPhaseLocked) begin
                unlockCntReg <= '0;
            end else if (unlockCntReg != 3'(OLFC_UNLOCK_CYC - 1)) begin
                unlockCntReg <= unlockCntReg + 1'b1;
            end
            if (unlockFault) begin
                lockReg <= 1'b0;  // [R6]
            end else if (lockTrue && !pllWasLockedReg) begin
                lockReg <= 1'b1;  // [R3]
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || !needStart || sleepMode) begin
            startCntReg <= '0;
            startedReg <= 1'b0;
        end else begin
            if (oscSwingValid && !startDone) begin
                startCntReg <= startCntReg + 1'b1;  // [R11]
            end
            startedReg <= startDone;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || monStateReg != OLFC_MON_WAIT) begin
            monCntReg <= '0;
        end else if (!monExpired) begin
            monCntReg <= monCntReg + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    assign currentSourceSel = csrcReg;  // [R23]
    assign clockReleased = needStart ? startedReg :
        (curPll ? pllWasLockedReg : 1'b1);  // [R4] [R11]
    assign clockFailTrap = trapReg;

    wire [31:0] ctlWord = {18'h0, csrcReg, 2'h0, nsrcReg, divSelReg,
        lockReg, 1'b0, cfReg, 1'b0, keepOnReg, swReqReg};  // [R2] [R23]
    wire [31:0] stWord = {28'h0, startedReg, monStateReg == OLFC_MON_RUN,
        slowOn, secOn};
    assign prdata = !psel ? 32'h0 : hitCtl ? ctlWord :
        hitSt ? stWord : 32'h0;
endmodule // olfc_oscillator_lock_failsafe_control

// file: rtl/olfc_pkg.sv
/*
 * Package for the oscillator lock and fail-safe control block:
 * control register layout, reset values, timing counts, carriers.
 * Assumes a 100 MHz sys_clk and an APB master with 32-bit data.
 */
package olfc_pkg;

    // Register byte offsets
    localparam logic [7:0] OLFC_OSCCTL_OFS = 8'h00;
    localparam logic [7:0] OLFC_STATUS_OFS = 8'h04;

    // Oscillator control register fields
    localparam int OLFC_SWREQ_BIT = 0;
    localparam int OLFC_KEEPON_BIT = 1;
    localparam int OLFC_CF_BIT = 3;
    localparam int OLFC_LOCK_BIT = 5;
    localparam int OLFC_DIV_LSB = 6;
    localparam int OLFC_NSRC_LSB = 8;
    localparam int OLFC_CSRC_LSB = 12;

    // Status register fields
    localparam int OLFC_ST_SECON_BIT = 0;
    localparam int OLFC_ST_SLOWON_BIT = 1;
    localparam int OLFC_ST_MON_BIT = 2;
    localparam int OLFC_ST_STARTED_BIT = 3;

    // Reset values
    localparam logic [1:0] OLFC_DIV_RST = 2'h0;
    localparam logic [1:0] OLFC_NSRC_RST = 2'h0;

    // Source encodings
    localparam logic [1:0] OLFC_SRC_SEC = 2'h0;
    localparam logic [1:0] OLFC_SRC_FAST = 2'h1;
    localparam logic [1:0] OLFC_SRC_SLOW = 2'h2;
    localparam logic [1:0] OLFC_SRC_PRI = 2'h3;

    // Timing
    localparam int OLFC_CLK_MHZ = 100;
    localparam int OLFC_LOCK_US = 20;
    localparam int OLFC_LOCK_CYC = OLFC_LOCK_US * OLFC_CLK_MHZ;
    localparam int OLFC_MON_US = 100;
    localparam int OLFC_MON_CYC = OLFC_MON_US * OLFC_CLK_MHZ;
    localparam int OLFC_START_CYC = 1024;
    localparam int OLFC_UNLOCK_CYC = 4;
    localparam int OLFC_PRE_W = 6;

    typedef enum logic [1:0] {
        OLFC_MUL4 = 2'b00,
        OLFC_MUL8 = 2'b01,
        OLFC_MUL16 = 2'b10,
        OLFC_MULOFF = 2'b11
    } olfc_mul_t;

    typedef enum logic [1:0] {
        OLFC_MON_IDLE = 2'b00,
        OLFC_MON_WAIT = 2'b01,
        OLFC_MON_RUN = 2'b10
    } olfc_mon_t;

    // Configuration straps
    typedef struct packed {
        logic [3:0] primaryModeConfig;
        logic switchMonitorConfigBit;
        logic watchdogEnable;
        logic [1:0] resetSource;
    } olfc_cfg_t;

    // Oscillator enables out to the analog side
    typedef struct packed {
        logic secondaryOn;
        logic slowRcOn;
        logic fastRcOn;
        logic primaryOn;
        logic pllOn;
        olfc_mul_t pllMul;
    } olfc_osc_t;

endpackage

// file: dv/olfc_checker.sv
/* Concurrent checks on the oscillator control block ports.
   Assumes binding onto the top module, sleepMode mostly low. */
module olfc_checker
import olfc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire olfc_pkg::olfc_cfg_t cfg,
    input wire logic sleepMode,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire olfc_pkg::olfc_osc_t oscEnable,
    input wire logic [1:0] currentSourceSel,
    input wire logic sysClockEnable,
    input wire logic clockReleased,
    input wire logic secondaryPinsOwned,
    input wire logic watchdogClockOn
);
timeunit 1ns;
timeprecision 1ns;
default clocking @(posedge sys_clk); endclocking
default disable iff (rst);
////////////////////////////////////////////////////////////////////////
logic keepOnReg;
logic [6:0] gapReg;
wire ctlWr = psel && penable && pwrite && paddr == OLFC_OSCCTL_OFS;
always_ff @(posedge sys_clk) begin
    if (rst) keepOnReg <= 1'h0;
    else if (ctlWr) keepOnReg <= pwdata[OLFC_KEEPON_BIT];
    gapReg <= (rst || sysClockEnable || !clockReleased) ? 7'h0 :
        gapReg + 7'h1;
end
////////////////////////////////////////////////////////////////////////
pll_mul_a: assert property (oscEnable.pllOn && cfg.primaryModeConfig[3:2] == 2'h2
    |-> oscEnable.pllMul == (cfg.primaryModeConfig[1:0] == 2'h0 ? OLFC_MUL4 :
    cfg.primaryModeConfig[1:0] == 2'h1 ? OLFC_MUL8 : OLFC_MUL16))
    else $error("pll multiplier wrong");
keep_on_a: assert property (keepOnReg |-> oscEnable.secondaryOn)
    else $error("secondary off with keep-on");
sec_off_a: assert property (!keepOnReg && currentSourceSel != OLFC_SRC_SEC
    |-> !oscEnable.secondaryOn) else $error("secondary on needlessly");
pins_own_a: assert property (secondaryPinsOwned == oscEnable.secondaryOn)
    else $error("pin ownership wrong");
fast_src_a: assert property (currentSourceSel == OLFC_SRC_FAST
    |-> oscEnable.fastRcOn) else $error("fast rc off");
mon_slow_a: assert property (!cfg.switchMonitorConfigBit && !sleepMode
    |-> oscEnable.slowRcOn) else $error("slow rc off under monitor");
wdt_clock_a: assert property (cfg.watchdogEnable |-> watchdogClockOn)
    else $error("watchdog clock lost");
div_gap_a: assert property (!sleepMode |-> gapReg < 7'h40)
    else $error("postscaler tick gap too long");
mon_off_a: assert property (psel && !pwrite && paddr == OLFC_STATUS_OFS
    && cfg.switchMonitorConfigBit |-> !prdata[OLFC_ST_MON_BIT])
    else $error("monitor running while disabled");
endmodule // olfc_checker

bind olfc_oscillator_lock_failsafe_control olfc_checker olfc_checker_inst (
    .sys_clk, .rst, .cfg, .sleepMode, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .oscEnable, .currentSourceSel, .sysClockEnable,
    .clockReleased,
    .secondaryPinsOwned, .watchdogClockOn);

// file: dv/olfc_osc_model.sv
/* Far-side oscillators and PLL: lock after settling, swing, failure.
   Assumes the bench steers lockOk, dropLock, swingOn and failNow. */
module olfc_osc_model
import olfc_pkg::*;
(
    input wire logic sys_clk,
    input wire olfc_pkg::olfc_osc_t oscEnable,
    input wire logic lockOk,
    input wire logic dropLock,
    input wire logic swingOn,
    input wire logic failNow,
    output logic pllPhaseLocked,
    output logic oscSwingValid,
    output logic oscClockFail
);
timeunit 1ns;
timeprecision 1ns;
logic [3:0] settleReg;
always_ff @(posedge sys_clk) begin
    if (oscEnable.pllOn !== 1'h1) settleReg <= 4'h0;
    else if (settleReg != 4'hf) settleReg <= settleReg + 4'h1;
end
assign pllPhaseLocked = lockOk && !dropLock && settleReg > 4'h5;
assign oscSwingValid = swingOn && (oscEnable.primaryOn || oscEnable.secondaryOn);
assign oscClockFail = failNow;
endmodule // olfc_osc_model

// file: dv/testbench.sv
/* Self-checking bench: APB accesses and one task per scenario.
   Assumes the far-side model and the bound checker. */
module testbench;
import olfc_pkg::*;
timeunit 1ns;
timeprecision 1ns;
logic sys_clk = 1'h0, rst = 1'h1, sleepMode = 1'h0, powerupTimerDone = 1'h0;
logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, rdErr;
logic [7:0] paddr = 8'h0;
logic [31:0] pwdata = 32'h0, prdata, rd;
logic lockOk = 1'h1, dropLock = 1'h0, swingOn = 1'h1, failNow = 1'h0;
logic pllPhaseLocked, oscSwingValid, oscClockFail, pready, pslverr;
logic clockReleased, clockFailTrap, sysClockEnable, secondaryPinsOwned;
logic watchdogClockOn;
logic [1:0] currentSourceSel;
olfc_cfg_t cfg = '0;
olfc_osc_t oscEnable;
int errCount = 0, totalChecks = 0, t, u;
localparam olfc_cfg_t PLL_CFG = '{4'h9, 1'h0, 1'h0, 2'h0};
always #5 sys_clk = ~sys_clk;
olfc_oscillator_lock_failsafe_control #(.LOCK_CYC(20), .MON_CYC(50))
    olfc_oscillator_lock_failsafe_control_inst (.sys_clk, .rst, .cfg,
    .sleepMode, .powerupTimerDone, .pllPhaseLocked, .oscSwingValid,
    .oscClockFail, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .oscEnable, .currentSourceSel, .clockReleased,
    .clockFailTrap, .sysClockEnable, .secondaryPinsOwned, .watchdogClockOn);
olfc_osc_model olfc_osc_model_inst (.sys_clk, .oscEnable, .lockOk,
    .dropLock, .swingOn, .failNow, .pllPhaseLocked, .oscSwingValid,
    .oscClockFail);
////////////////////////////////////////////////////////////////////////
task automatic finishTest();
    if (errCount == 0 && totalChecks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
endtask
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
        errCount++;
        $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
endtask
task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
endtask
task automatic count(input int n, input bit trap, output int c);
    c = 0;
    repeat (n) begin
        @(negedge sys_clk);
        c += trap ? (clockFailTrap === 1'h1) : (sysClockEnable === 1'h1);
    end
endtask
task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do begin
        @(posedge sys_clk);
        n++;
    end while (pready !== 1'h1 && n < 16);
    rd = prdata;
    rdErr = pslverr;
    chk(32'(n < 16), 32'h1);
    psel <= 1'h0;
    penable <= 1'h0;
endtask
function automatic logic [31:0] ctlw(input logic [1:0] dv, input logic k,
    input logic cf);
    return 32'h300 | {24'h0, dv, 6'h0} | {30'h0, k, 1'h0} | {28'h0, cf, 3'h0};
endfunction
task automatic doReset(input olfc_cfg_t c);
    @(posedge sys_clk);
    rst <= 1'h1;
    cfg <= c;
    powerupTimerDone <= 1'h0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'h0;
    powerupTimerDone <= 1'h1;
endtask
////////////////////////////////////////////////////////////////////////
task automatic testLock();
    apb(1'h0, OLFC_OSCCTL_OFS, 32'h0);
    chk(rd[OLFC_LOCK_BIT], 1'h0);
    chk(rd[13:12], OLFC_SRC_PRI);
    chk(oscEnable.pllMul, OLFC_MUL8);
    cyc(40);
    apb(1'h0, OLFC_OSCCTL_OFS, 32'h0);
    chk(rd[OLFC_LOCK_BIT], 1'h1);
    apb(1'h0, 8'h08, 32'h0);
    chk({rdErr, rd[30:0]}, 32'h80000000);
endtask
task automatic testUnlock();
    dropLock <= 1'h1;
    count(3, 1'h1, t);
    dropLock <= 1'h0;
    count(4, 1'h1, u);
    chk(t + u, 0);
    dropLock <= 1'h1;
    count(8, 1'h1, t);
    dropLock <= 1'h0;
    count(3, 1'h1, u);
    chk(32'(t + u > 0), 32'h1);
    apb(1'h0, OLFC_OSCCTL_OFS, 32'h0);
    chk(rd[OLFC_LOCK_BIT], 1'h0);
    chk(rd[13:12], OLFC_SRC_PRI);
endtask
task automatic testPost();
    for (int k = 0; k < 4; k++) begin
        apb(1'h1, OLFC_OSCCTL_OFS, ctlw(k[1:0], 1'h0, 1'h1));
        cyc(70);
        count(128, 1'h0, t);
        chk(t, 128 >> (2 * k));
    end
endtask
task automatic testKeep();
    apb(1'h1, OLFC_OSCCTL_OFS, ctlw(2'h0, 1'h1, 1'h1));
    cyc(1);
    chk(oscEnable.secondaryOn, 1'h1);
    chk(secondaryPinsOwned, 1'h1);
    apb(1'h1, OLFC_OSCCTL_OFS, ctlw(2'h0, 1'h0, 1'h1));
    cyc(1);
    chk(oscEnable.secondaryOn, 1'h0);
endtask
task automatic testFail();
    failNow <= 1'h1;
    count(4, 1'h1, t);
    failNow <= 1'h0;
    count(2, 1'h1, u);
    chk(32'(t + u > 0), 32'h1);
    chk(currentSourceSel, OLFC_SRC_FAST);
    chk(oscEnable.fastRcOn, 1'h1);
    apb(1'h0, OLFC_OSCCTL_OFS, 32'h0);
    chk({rd[13:12], rd[3], rd[0]}, 4'h6);
    apb(1'h1, OLFC_OSCCTL_OFS, ctlw(2'h0, 1'h0, 1'h1));
    apb(1'h0, OLFC_OSCCTL_OFS, 32'h0);
    chk(rd[OLFC_CF_BIT], 1'h1);
    apb(1'h1, OLFC_OSCCTL_OFS, ctlw(2'h0, 1'h0, 1'h0));
    apb(1'h0, OLFC_OSCCTL_OFS, 32'h0);
    chk(rd[OLFC_CF_BIT], 1'h0);
endtask
task automatic testNoLock();
    lockOk <= 1'h0;
    doReset(PLL_CFG);
    count(30, 1'h1, t);
    chk(t, 0);
    chk(currentSourceSel, OLFC_SRC_PRI);
    count(60, 1'h1, t);
    chk(32'(t > 0), 32'h1);
    chk(currentSourceSel, OLFC_SRC_FAST);
    lockOk <= 1'h1;
endtask
task automatic testXtal();
    for (int k = 0; k < 2; k++) begin
        swingOn <= 1'h0;
        doReset('{4'h4, 1'h1, 1'h1, k[0] ? 2'h2 : 2'h0});
        cyc(100);
        swingOn <= 1'h1;
        cyc(1000);
        chk(clockReleased, 1'h0);
        cyc(40);
        chk(clockReleased, 1'h1);
    end
    apb(1'h0, OLFC_STATUS_OFS, 32'h0);
    chk(rd[OLFC_ST_MON_BIT], 1'h0);
endtask
////////////////////////////////////////////////////////////////////////
initial begin
    doReset(PLL_CFG);
    testLock();
    testUnlock();
    testPost();
    testKeep();
    testFail();
    testNoLock();
    testXtal();
    finishTest();
end
initial begin
    #200000;
    errCount++;
    finishTest();
end
endmodule // testbench
